// ===== bench/eprom_checks_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module eprom_checks
    import eprom_prog_pkg::*;
#(parameter int PULSE_CYCLES = PULSE_CYC) (
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              reqValid,
    input wire logic              reqReady,
    input wire logic              reqProgram,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqData,
    input wire logic              rspValid,
    input wire logic [DATA_W-1:0] rspData,
    input wire logic              rspVerifyOk,
    input wire logic              rspBadBits,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [DATA_W-1:0] memDataIn,
    input wire logic [DATA_W-1:0] memDataOut,
    input wire logic              memDataOe,
    input wire logic              chipEnable_n,
    input wire logic              outputEnable_n,
    input wire logic              write_strobe_n,
    input wire logic              vppHigh
);
    logic [CNT_W-1:0] lowCnt_reg;
    logic [CNT_W-1:0] lowCnt_next;
    always_comb lowCnt_next = write_strobe_n ? '0 : lowCnt_reg + 1'b1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) lowCnt_reg <= '0;
        else lowCnt_reg <= lowCnt_next;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    strobe_mode_a: assert property (!write_strobe_n |-> !chipEnable_n && vppHigh)
        else $error("strobe low outside program mode");
    vpp_lead_a: assert property ($fell(write_strobe_n) |-> $past(vppHigh, 10))
        else $error("supply not raised ahead of strobe");
    ce_hold_a: assert property (vppHigh |-> !chipEnable_n)
        else $error("chip enable released under high supply");
    strobe_data_a: assert property (!write_strobe_n |-> memDataOe)
        else $error("data not driven during strobe");
    pulse_stable_a: assert property (!write_strobe_n |-> $stable(memAddr) && $stable(memDataOut))
        else $error("address or data moved during strobe");
    pulse_len_a: assert property ($rose(write_strobe_n) |->
        lowCnt_reg >= PULSE_CYCLES && lowCnt_reg <= PULSE_CYCLES + 1)
        else $error("strobe pulse length wrong");
    pulse_max_a: assert property (lowCnt_reg <= PULSE_CYCLES + 1)
        else $error("strobe held low too long");
    one_pulse_a: assert property ($rose(write_strobe_n) |-> write_strobe_n throughout (##[1:100] rspValid))
        else $error("second pulse or no answer");
    no_clash_a: assert property (!outputEnable_n |-> write_strobe_n && !memDataOe && !chipEnable_n)
        else $error("outputs enabled while host drives");
    readback_a: assert property ($rose(write_strobe_n) |->
        ##[1:100] (!chipEnable_n && !outputEnable_n && write_strobe_n))
        else $error("no readback after pulse");
endmodule // eprom_checks
bind eprom_programmer eprom_checks #(.PULSE_CYCLES(PULSE_CYCLES)) eprom_checks_i (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .reqValid       (reqValid),
    .reqReady       (reqReady),
    .reqProgram     (reqProgram),
    .reqAddr        (reqAddr),
    .reqData        (reqData),
    .rspValid       (rspValid),
    .rspData        (rspData),
    .rspVerifyOk    (rspVerifyOk),
    .rspBadBits     (rspBadBits),
    .memAddr        (memAddr),
    .memDataIn      (memDataIn),
    .memDataOut     (memDataOut),
    .memDataOe      (memDataOe),
    .chipEnable_n   (chipEnable_n),
    .outputEnable_n (outputEnable_n),
    .write_strobe_n (write_strobe_n),
    .vppHigh        (vppHigh)
);
`default_nettype wire

// ===== bench/eprom_model.sv
`timescale 1ns/10ps
`default_nettype none
module eprom_model
    import eprom_prog_pkg::*;
#(parameter int PULSE_MIN = PULSE_CYC) (
    input  wire logic              clk_sys,
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic [DATA_W-1:0] hostByte,
    input  wire logic              hostOe,
    input  wire logic              chipEnable_n,
    input  wire logic              outputEnable_n,
    input  wire logic              write_strobe_n,
    input  wire logic              vppHigh,
    output logic [DATA_W-1:0]      dataWire
);
    // ************************************************************
    // array and pin behaviour
    // ************************************************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last;
    int                lowCnt;
    int                rdCnt;
    logic              prevStrobe;
    initial begin
        for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = ERASED_BYTE;
        last = 8'h00;
        lowCnt = 0;
        rdCnt = 0;
        prevStrobe = 1'b1;
    end
    always @(posedge clk_sys) begin
        // a short pulse leaves the cell untouched; cells only go one to zero
        // non-blocking so the host's input flops never race the pin update
        if (write_strobe_n && !prevStrobe && lowCnt >= PULSE_MIN) begin
            mem[memAddr] <= mem[memAddr] & hostByte;
        end
        lowCnt <= (!write_strobe_n && vppHigh && !chipEnable_n) ? lowCnt + 1 : 0;
        prevStrobe <= write_strobe_n;
        rdCnt <= (!chipEnable_n && !outputEnable_n && write_strobe_n) ? rdCnt + 1 : 0;
        last <= dataWire;
    end
    // undriven bus shows a toggling pattern, never the stale byte
    assign dataWire = hostOe ? hostByte : (rdCnt >= 3 ? mem[memAddr] : ~last);
endmodule // eprom_model
`default_nettype wire

// ===== bench/uv_eprom_program_read_test.sv
`timescale 1ns/10ps
`default_nettype none
module uv_eprom_program_read_test;
    import eprom_prog_pkg::*;
    localparam int PULSE = 50;
    logic clk_sys = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqProgram = 1'b0;
    logic [ADDR_W-1:0] reqAddr = '0, memAddr;
    logic [DATA_W-1:0] reqData = '0, rspData, memDataIn, memDataOut;
    logic reqReady, rspValid, rspVerifyOk, rspBadBits, memDataOe;
    logic chipEnable_n, outputEnable_n, write_strobe_n, vppHigh;
    int errors = 0, check_count = 0, cycles = 0;
    initial forever #50 clk_sys = ~clk_sys;
    eprom_programmer #(.PULSE_CYCLES(PULSE)) eprom_programmer_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady), .reqProgram(reqProgram),
        .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
        .rspVerifyOk(rspVerifyOk), .rspBadBits(rspBadBits), .memAddr(memAddr),
        .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe),
        .chipEnable_n(chipEnable_n), .outputEnable_n(outputEnable_n),
        .write_strobe_n(write_strobe_n), .vppHigh(vppHigh));
    eprom_model #(.PULSE_MIN(PULSE)) eprom_model_i (.clk_sys(clk_sys), .memAddr(memAddr),
        .hostByte(memDataOut), .hostOe(memDataOe), .chipEnable_n(chipEnable_n),
        .outputEnable_n(outputEnable_n), .write_strobe_n(write_strobe_n), .vppHigh(vppHigh),
        .dataWire(memDataIn));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ceiling sized for a handful of 50-cycle programs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done;
        end
    end
    task automatic req(input logic prog, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin @(negedge clk_sys); n++; end
        reqValid = 1'b1; reqProgram = prog; reqAddr = a; reqData = d;
        @(negedge clk_sys);
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 1000) begin @(negedge clk_sys); n++; end
        check({15'h0, rspValid}, 16'h0001);
    endtask
    task t_reset;
        check({12'h0, reqReady, write_strobe_n, vppHigh, memDataOe}, 16'h000C);
        check({14'h0, chipEnable_n, outputEnable_n}, 16'h0003);
    endtask
    task t_read_erased;
        req(1'b0, 13'h0000, 8'h00);
        check({8'h0, rspData}, 16'h00FF);
        req(1'b0, 13'h1FFF, 8'h00);
        check({8'h0, rspData}, 16'h00FF);
        check({3'h0, memAddr}, 16'h1FFF);
    endtask
    task t_program;
        req(1'b1, 13'h1234, 8'hA5);
        check({6'h0, rspVerifyOk, rspBadBits, rspData}, 16'h02A5);
        req(1'b1, 13'h0001, 8'h3C);
        check({6'h0, rspVerifyOk, rspBadBits, rspData}, 16'h023C);
        req(1'b0, 13'h1234, 8'h00);
        check({8'h0, rspData}, 16'h00A5);
        req(1'b0, 13'h0001, 8'h00);
        check({8'h0, rspData}, 16'h003C);
    endtask
    task t_zero_to_one;
        req(1'b1, 13'h1234, 8'hFF);
        check({6'h0, rspVerifyOk, rspBadBits, rspData}, 16'h01A5);
        req(1'b1, 13'h1234, 8'h05);
        check({6'h0, rspVerifyOk, rspBadBits, rspData}, 16'h0205);
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        t_reset;
        t_read_erased;
        t_program;
        t_zero_to_one;
        test_done;
    end
endmodule // uv_eprom_program_read_test
`default_nettype wire

// ===== inc/delay_if.sv
`timescale 1ns/10ps
`default_nettype none
interface delay_if #(parameter int CNT_W = 20);
    logic             load;
    logic [CNT_W-1:0] count;
    logic             done;
    modport ctrl  (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// ===== inc/eprom_prog_pkg.sv
package eprom_prog_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

    // ************************************************************
    // timing, figures in their own units
    // ************************************************************
    localparam int CLK_NS          = 100;
    localparam int PULSE_MS        = 50;
    localparam int PULSE_MAX_MS    = 55;
    localparam int SETUP_US        = 2;
    localparam int HOLD_US         = 2;
    localparam int VPP_SETUP_US    = 2;
    localparam int ACCESS_NS       = 300;
    localparam int FLOAT_NS        = 130;

    localparam int PULSE_CYC     = (PULSE_MS * 1000000) / CLK_NS;
    localparam int PULSE_MAX_CYC = (PULSE_MAX_MS * 1000000) / CLK_NS;
    localparam int SETUP_CYC     = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC      = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int VPP_CYC       = (VPP_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int FLOAT_CYC     = (FLOAT_NS + CLK_NS - 1) / CLK_NS;

    localparam int CNT_W = 20;

    typedef enum logic [1:0] {
        CMD_READ,
        CMD_PROGRAM
    } cmd_t;
endpackage

// ===== src/delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module delay_timer #(
    parameter int CNT_W = 20
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    delay_if.timer    dly
);
    logic [CNT_W-1:0] left_reg;
    logic [CNT_W-1:0] left_next;

    always_comb begin
        left_next = left_reg;
        if (dly.load) begin
            left_next = dly.count;
        end else if (left_reg != '0) begin
            left_next = left_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            left_reg <= '0;
        end else begin
            left_reg <= left_next;
        end
    end

    // done is a level from the register alone; folding load in would loop back through the caller
    assign dly.done = (left_reg == '0);
endmodule // delay_timer
`default_nettype wire

// ===== src/eprom_programmer.sv
// How it works
// - raise supply, enable and strobe low
// - drive address and data during programming
// - one 50 ms strobe after stable setup
// - strobe length set by PULSE_CYCLES alone, not clamped to 55 ms (PULSE_MAX_CYC unused)
// - one pulse per location, any order
`timescale 1ns/10ps
`default_nettype none
module eprom_programmer
    import eprom_prog_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int OE_LAG       = 1
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // user side
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire logic              reqProgram,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqData,
    output logic                   rspValid,
    output logic [DATA_W-1:0]      rspData,
    output logic                   rspVerifyOk,
    output logic                   rspBadBits,
    // device pins
    output logic [ADDR_W-1:0]      memAddr,
    input  wire logic [DATA_W-1:0] memDataIn,
    output logic [DATA_W-1:0]      memDataOut,
    output logic                   memDataOe,
    output logic                   chipEnable_n,
    output logic                   outputEnable_n,
    output logic                   write_strobe_n,
    output logic                   vppHigh
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [3:0] {
        S_IDLE, S_RD_CE, S_RD_OE, S_RD_SAMPLE,
        S_PG_VPP, S_PG_SETUP, S_PG_PULSE, S_PG_HOLD, S_PG_FLOAT
    } state_t;

    state_t              state_reg,  state_next;
    logic [ADDR_W-1:0]   addr_reg,   addr_next;
    logic [DATA_W-1:0]   wdata_reg,  wdata_next;
    logic                prog_reg,   prog_next;
    logic                ce_n_reg,   ce_n_next;
    logic                oe_n_reg,   oe_n_next;
    logic                pgm_n_reg,  pgm_n_next;
    logic                vpp_reg,    vpp_next;
    logic                dOe_reg,    dOe_next;
    logic                rspV_reg,   rspV_next;
    logic [DATA_W-1:0]   rspD_reg,   rspD_next;
    logic                ok_reg,     ok_next;
    logic                bad_reg,    bad_next;

    // ************************************************************
    // input sampling: three flops, change accepted when 2 and 3 agree
    // ************************************************************
    logic [DATA_W-1:0] din1_reg, din2_reg, din3_reg, dinStable_reg, dinStable_next;

    always_comb begin
        dinStable_next = dinStable_reg;
        if (din2_reg == din3_reg) begin
            dinStable_next = din3_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            din1_reg      <= ERASED_BYTE;
            din2_reg      <= ERASED_BYTE;
            din3_reg      <= ERASED_BYTE;
            dinStable_reg <= ERASED_BYTE;
        end else begin
            din1_reg      <= memDataIn;
            din2_reg      <= din1_reg;
            din3_reg      <= din2_reg;
            dinStable_reg <= dinStable_next;
        end
    end

    // ************************************************************
    // delay timer
    // ************************************************************
    delay_if #(.CNT_W(CNT_W)) dly ();

    delay_timer #(.CNT_W(CNT_W)) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .dly     (dly)
    );

    // sampler adds four cycles of latency to the read data
    localparam int SAMPLE_CYC = ACCESS_CYC + 4;

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        prog_next  = prog_reg;
        ce_n_next  = ce_n_reg;
        oe_n_next  = oe_n_reg;
        pgm_n_next = pgm_n_reg;
        vpp_next   = vpp_reg;
        dOe_next   = dOe_reg;
        rspV_next  = 1'b0;
        rspD_next  = rspD_reg;
        ok_next    = ok_reg;
        dly.load   = 1'b0;
        dly.count  = '0;
        unique case (state_reg)
            S_IDLE: begin
                if (reqValid) begin
                    addr_next  = reqAddr;
                    wdata_next = reqData;
                    prog_next  = reqProgram;
                    ce_n_next  = 1'b0;
                    dly.load   = 1'b1;
                    if (reqProgram) begin
                        vpp_next  = 1'b1;
                        dly.count = CNT_W'(VPP_CYC);
                        state_next = S_PG_VPP;
                    end else begin
                        dly.count  = CNT_W'(OE_LAG);
                        state_next = S_RD_CE;
                    end
                end
            end
            S_RD_CE: begin
                if (dly.done) begin
                    oe_n_next  = 1'b0;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(SAMPLE_CYC);
                    state_next = S_RD_OE;
                end
            end
            S_RD_OE: begin
                if (dly.done) begin
                    state_next = S_RD_SAMPLE;
                end
            end
            S_RD_SAMPLE: begin
                rspD_next = dinStable_reg;
                rspV_next = 1'b1;
                ok_next   = !prog_reg || (dinStable_reg == wdata_reg);
                oe_n_next = 1'b1;
                ce_n_next = 1'b1;
                vpp_next  = 1'b0;
                state_next = S_IDLE;
            end
            S_PG_VPP: begin
                if (dly.done) begin
                    dOe_next   = 1'b1;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(SETUP_CYC);
                    state_next = S_PG_SETUP;
                end
            end
            S_PG_SETUP: begin
                if (dly.done) begin
                    pgm_n_next = 1'b0;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(PULSE_CYCLES);
                    state_next = S_PG_PULSE;
                end
            end
            S_PG_PULSE: begin
                // one bounded pulse, never a steady low level
                if (dly.done) begin
                    pgm_n_next = 1'b1;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(HOLD_CYC);
                    state_next = S_PG_HOLD;
                end
            end
            S_PG_HOLD: begin
                if (dly.done) begin
                    dOe_next   = 1'b0;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(FLOAT_CYC + 1);
                    state_next = S_PG_FLOAT;
                end
            end
            S_PG_FLOAT: begin
                // verify read under the high supply, strobe high
                if (dly.done) begin
                    oe_n_next  = 1'b0;
                    dly.load   = 1'b1;
                    dly.count  = CNT_W'(SAMPLE_CYC);
                    state_next = S_RD_OE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // a zero cell cannot return to one without erasure
    always_comb begin
        bad_next = bad_reg;
        if (state_reg == S_IDLE && reqValid && reqProgram) begin
            bad_next = 1'b0;
        end else if (state_reg == S_RD_SAMPLE && prog_reg) begin
            // requested ones over programmed zeros are a failed verify
            bad_next = |(wdata_reg & ~dinStable_reg);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            addr_reg  <= '0;
            wdata_reg <= ERASED_BYTE;
            prog_reg  <= 1'b0;
            ce_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            pgm_n_reg <= 1'b1;
            vpp_reg   <= 1'b0;
            dOe_reg   <= 1'b0;
            rspV_reg  <= 1'b0;
            rspD_reg  <= ERASED_BYTE;
            ok_reg    <= 1'b0;
            bad_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            prog_reg  <= prog_next;
            ce_n_reg  <= ce_n_next;
            oe_n_reg  <= oe_n_next;
            pgm_n_reg <= pgm_n_next;
            vpp_reg   <= vpp_next;
            dOe_reg   <= dOe_next;
            rspV_reg  <= rspV_next;
            rspD_reg  <= rspD_next;
            ok_reg    <= ok_next;
            bad_reg   <= bad_next;
        end
    end

    assign reqReady       = (state_reg == S_IDLE);
    assign rspValid       = rspV_reg;
    assign rspData        = rspD_reg;
    assign rspVerifyOk    = ok_reg;
    assign rspBadBits     = bad_reg;
    assign memAddr        = addr_reg;
    assign memDataOut     = wdata_reg;
    assign memDataOe      = dOe_reg;
    assign chipEnable_n   = ce_n_reg;
    assign outputEnable_n = oe_n_reg;
    assign write_strobe_n = pgm_n_reg;
    assign vppHigh        = vpp_reg;
endmodule // eprom_programmer
`default_nettype wire
